/* rtl/ctsv_pkg.sv */
// ==========================================================================
// Shared constants and carriers for the transformer-circuit supervisor
package ctsv_pkg;
  localparam int MAG_W = 16;
  // Magnitude scale: 1 LSB = 0.001 x nominal current
  localparam logic [MAG_W-1:0] UPPER_RST = 16'h04B0;
  localparam logic [MAG_W-1:0] LOWER_RST = 16'h0064;
  localparam logic [MAG_W-1:0] SUMDIFF_RST = 16'h0064;
  // Ratios are fractions of 256
  localparam logic [7:0] PRATIO_RST = 8'h80;
  localparam logic [7:0] SRATIO_RST = 8'h80;
  localparam logic [15:0] DELAY_RST = 16'h0064;
  localparam int RATIO_SHIFT = 8;
  localparam logic [23:0] PCT_FULL = 24'h000064;
  localparam logic [23:0] PCT_LOW = 24'h000061;
  localparam logic [23:0] PCT_HIGH = 24'h000067;
  // Parameter sets
  localparam int GROUPS = 8;
  localparam int GRP_W = 3;
  // Residual source and polarity codes
  localparam logic [1:0] RES_NONE = 2'h0;
  localparam logic [1:0] RES_ONE = 2'h1;
  localparam logic [1:0] RES_TWO = 2'h2;
  localparam logic POL_ADD = 1'b0;
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int STAMP_RES_NS = 1000000;
  localparam int MS_CYCLES = STAMP_RES_NS / CLK_PERIOD_NS;
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h008;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h00C;
  localparam logic [11:0] OFS_ALARM_CNT = 12'h010;
  localparam logic [11:0] OFS_BLOCK_CNT = 12'h014;
  localparam logic [11:0] OFS_CNT_CLR = 12'h018;
  localparam logic [11:0] OFS_TIME_MS = 12'h01C;
  localparam logic [11:0] OFS_SET_BASE = 12'h040;
  localparam logic [11:0] OFS_SET_END = 12'h140;
  localparam int SET_STRIDE_LSB = 5;
  // Field index inside one parameter set
  localparam logic [2:0] FLD_UPPER = 3'h0;
  localparam logic [2:0] FLD_LOWER = 3'h1;
  localparam logic [2:0] FLD_PRATIO = 3'h2;
  localparam logic [2:0] FLD_SRATIO = 3'h3;
  localparam logic [2:0] FLD_SUMDIFF = 3'h4;
  localparam logic [2:0] FLD_DELAY = 3'h5;
  // Control register fields
  localparam int CTRL_RES_LSB = 0;
  localparam int CTRL_POL_BIT = 2;
  localparam int CTRL_SUM_BIT = 3;
  // Interrupt / event bit positions
  localparam int EV_ALARM_ON = 0;
  localparam int EV_ALARM_OFF = 1;
  localparam int EV_BLOCK_ON = 2;
  localparam int EV_BLOCK_OFF = 3;
  localparam int EV_W = 4;

  typedef struct packed {
    logic [MAG_W-1:0] phase_a_current;
    logic [MAG_W-1:0] phase_b_current;
    logic [MAG_W-1:0] phase_c_current;
    logic [MAG_W-1:0] residual_input_one;
    logic [MAG_W-1:0] residual_input_two;
    logic [MAG_W-1:0] positive_sequence_current;
    logic [MAG_W-1:0] negative_sequence_current;
  } ctsv_meas_t;

  typedef struct packed {
    logic [EV_W-1:0] kind;
    logic [31:0] stamp;
  } ctsv_event_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TIMING = 2'b01,
    ST_ALARM = 2'b11,
    ST_BLOCKED = 2'b10
  } ctsv_state_t;
endpackage

/* rtl/ctsv_top.sv */
// Behaviour
// - Phase magnitudes always evaluated; residual path used only when enabled.
// - Blocking input and active set take effect while running.
// - Eight parameter sets, active one chosen by one group select input.
// - Stages: capture, comparison, block check, delay timer, outputs.
// - Any phase above upper threshold removes the alarm condition.
// - Needs one phase above and one phase below the lower threshold.
// - Smallest over largest phase must be below the phase ratio limit.
// - Negative over positive sequence must exceed the sequence ratio limit.
// - Optional: phase sum with residual must exceed summation limit.
// - Alarm only after the condition held for the whole delay.
// - Alarm and blocked outputs drive routing and user logic directly.
// - On and off events for both outputs with 1 ms stamps.
// - Cumulative alarm and blocked counters, each clearable by command.
// - Threshold release uses 97 % and 103 % hysteresis.
// - Residual source: 0 none, 1 first input, 2 second input.
// - Residual polarity in summation: 0 adds, 1 subtracts.
// - Magnitudes arrive with a strobe on a 5 ms base.
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ctsv_top
  import ctsv_pkg::*;
#(
  parameter int TICK_CYCLES = MS_CYCLES
)(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic MEAS_VALID,
  input wire ctsv_meas_t MEAS,
  input wire logic BLOCK_IN,
  input wire logic [GRP_W-1:0] GROUP_SEL,
  output logic ALARM,
  output logic BLOCKED,
  output logic EVT_VALID,
  output ctsv_event_t EVT,
  output logic IRQ
);
  // ========================================================================
  // Helpers
  function automatic logic set_field_ok(input logic [11:0] a);
    logic [11:0] ofs;
    ofs = a - OFS_SET_BASE;
    return (a >= OFS_SET_BASE) && (a < OFS_SET_END) && (ofs[4:2] <= FLD_DELAY)
      && (a[1:0] == 2'h0);
  endfunction

  // Set when above thr, released below 97 % of thr
  function automatic logic hyst_above(input logic prev, input logic [MAG_W-1:0] m,
                                      input logic [MAG_W-1:0] thr);
    if (m > thr)
      return 1'b1;
    else if (24'(m) * PCT_FULL < 24'(thr) * PCT_LOW)
      return 1'b0;
    return prev;
  endfunction

  // Set when below thr, released above 103 % of thr
  function automatic logic hyst_below(input logic prev, input logic [MAG_W-1:0] m,
                                      input logic [MAG_W-1:0] thr);
    if (m < thr)
      return 1'b1;
    else if (24'(m) * PCT_FULL > 24'(thr) * PCT_HIGH)
      return 1'b0;
    return prev;
  endfunction

  // ========================================================================
  // Register bus
  logic wr_acc;
  logic [11:0] set_ofs;
  logic [GRP_W-1:0] wr_grp;
  logic [2:0] wr_fld;
  logic addr_ok;
  logic [3:0] ctrl_reg;
  logic [EV_W-1:0] irq_stat_reg;
  logic [EV_W-1:0] irq_mask_reg;
  logic [31:0] alarm_cnt_reg;
  logic [31:0] block_cnt_reg;
  logic [31:0] ms_count_reg;
  logic [MAG_W-1:0] upper_mem [GROUPS];
  logic [MAG_W-1:0] lower_mem [GROUPS];
  logic [7:0] pratio_mem [GROUPS];
  logic [7:0] sratio_mem [GROUPS];
  logic [MAG_W-1:0] sumdiff_mem [GROUPS];
  logic [15:0] delay_mem [GROUPS];
  ctsv_state_t state_reg;
  ctsv_state_t state_next;
  logic cond_reg;
  logic [GRP_W-1:0] grp_reg;

  assign set_ofs = PADDR - OFS_SET_BASE;
  assign wr_grp = set_ofs[SET_STRIDE_LSB +: GRP_W];
  assign wr_fld = set_ofs[4:2];
  assign addr_ok = set_field_ok(PADDR) || (PADDR inside {OFS_CTRL, OFS_STATUS,
    OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_ALARM_CNT, OFS_BLOCK_CNT, OFS_CNT_CLR, OFS_TIME_MS});
  assign wr_acc = PSEL && PENABLE && PWRITE;
  // Zero wait states keeps the bus simple; error only for unmapped words
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;

  // Read mux
  always_comb
  begin
    PRDATA = 32'h0000_0000;
    if (set_field_ok(PADDR))
    begin
      unique case (wr_fld)
        FLD_UPPER: PRDATA = {16'h0000, upper_mem[wr_grp]};
        FLD_LOWER: PRDATA = {16'h0000, lower_mem[wr_grp]};
        FLD_PRATIO: PRDATA = {24'h000000, pratio_mem[wr_grp]};
        FLD_SRATIO: PRDATA = {24'h000000, sratio_mem[wr_grp]};
        FLD_SUMDIFF: PRDATA = {16'h0000, sumdiff_mem[wr_grp]};
        default: PRDATA = {16'h0000, delay_mem[wr_grp]};
      endcase
    end
    else
    begin
      unique case (PADDR)
        OFS_CTRL: PRDATA = {28'h0000000, ctrl_reg};
        OFS_STATUS: PRDATA = {24'h000000, grp_reg, state_reg, cond_reg, BLOCKED, ALARM};
        OFS_IRQ_STAT: PRDATA = {28'h0000000, irq_stat_reg};
        OFS_IRQ_MASK: PRDATA = {28'h0000000, irq_mask_reg};
        OFS_ALARM_CNT: PRDATA = alarm_cnt_reg;
        OFS_BLOCK_CNT: PRDATA = block_cnt_reg;
        OFS_TIME_MS: PRDATA = ms_count_reg;
        default: PRDATA = 32'h0000_0000;
      endcase
    end
  end

  // Control and mask registers
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      ctrl_reg <= 4'h0;
      irq_mask_reg <= 4'h0;
    end
    else if (wr_acc && PADDR == OFS_CTRL)
      ctrl_reg <= PWDATA[3:0];
    else if (wr_acc && PADDR == OFS_IRQ_MASK)
      irq_mask_reg <= PWDATA[EV_W-1:0];
  end

  // Eight parameter sets, editable while the function runs
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      for (int g = 0; g < GROUPS; g++)
      begin
        upper_mem[g] <= UPPER_RST;
        lower_mem[g] <= LOWER_RST;
        pratio_mem[g] <= PRATIO_RST;
        sratio_mem[g] <= SRATIO_RST;
        sumdiff_mem[g] <= SUMDIFF_RST;
        delay_mem[g] <= DELAY_RST;
      end
    end
    else if (wr_acc && set_field_ok(PADDR))
    begin
      unique case (wr_fld)
        FLD_UPPER: upper_mem[wr_grp] <= PWDATA[MAG_W-1:0];
        FLD_LOWER: lower_mem[wr_grp] <= PWDATA[MAG_W-1:0];
        FLD_PRATIO: pratio_mem[wr_grp] <= PWDATA[7:0];
        FLD_SRATIO: sratio_mem[wr_grp] <= PWDATA[7:0];
        FLD_SUMDIFF: sumdiff_mem[wr_grp] <= PWDATA[MAG_W-1:0];
        default: delay_mem[wr_grp] <= PWDATA[15:0];
      endcase
    end
  end

  // ========================================================================
  // Millisecond time base for stamps and the delay timer
  logic [$clog2(TICK_CYCLES)-1:0] pre_reg;
  logic ms_tick;
  assign ms_tick = (pre_reg == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      pre_reg <= '0;
      ms_count_reg <= 32'h0000_0000;
    end
    else if (ms_tick)
    begin
      pre_reg <= '0;
      ms_count_reg <= ms_count_reg + 32'h0000_0001;
    end
    else
      pre_reg <= pre_reg + 1'b1;
  end

  // ========================================================================
  // Stage 1: capture a measurement set and pick the residual source
  ctsv_meas_t meas_reg;
  logic [MAG_W-1:0] res_mag_reg;
  logic s1_valid_reg;

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      meas_reg <= '0;
      res_mag_reg <= '0;
      s1_valid_reg <= 1'b0;
      grp_reg <= '0;
    end
    else
    begin
      s1_valid_reg <= MEAS_VALID;
      if (MEAS_VALID)
      begin
        meas_reg <= MEAS;
        grp_reg <= GROUP_SEL;
        unique case (ctrl_reg[CTRL_RES_LSB +: 2])
          RES_ONE: res_mag_reg <= MEAS.residual_input_one;
          RES_TWO: res_mag_reg <= MEAS.residual_input_two;
          default: res_mag_reg <= '0;
        endcase
      end
    end
  end

  // ========================================================================
  // Stage 2: threshold comparators with release hysteresis
  logic [MAG_W-1:0] ph [3];
  logic [MAG_W-1:0] ph_max;
  logic [MAG_W-1:0] ph_min;
  logic [2:0] over_upper_reg;
  logic [2:0] above_lower_reg;
  logic [2:0] below_lower_reg;
  logic ratio_ok_reg;
  logic seq_ok_reg;
  logic sum_ok_reg;
  logic s2_valid_reg;
  logic signed [MAG_W+2:0] sum_val;
  logic [MAG_W+2:0] sum_abs;

  assign ph[0] = meas_reg.phase_a_current;
  assign ph[1] = meas_reg.phase_b_current;
  assign ph[2] = meas_reg.phase_c_current;
  assign ph_max = (ph[0] > ph[1]) ? ((ph[0] > ph[2]) ? ph[0] : ph[2])
                                  : ((ph[1] > ph[2]) ? ph[1] : ph[2]);
  assign ph_min = (ph[0] < ph[1]) ? ((ph[0] < ph[2]) ? ph[0] : ph[2])
                                  : ((ph[1] < ph[2]) ? ph[1] : ph[2]);
  // Residual sign by polarity setting
  assign sum_val = (MAG_W+3)'(ph[0]) + (MAG_W+3)'(ph[1]) + (MAG_W+3)'(ph[2])
    + ((ctrl_reg[CTRL_POL_BIT] == POL_ADD) ? (MAG_W+3)'(res_mag_reg)
                                          : -(MAG_W+3)'(res_mag_reg));
  assign sum_abs = sum_val[MAG_W+2] ? (MAG_W+3)'(-sum_val) : (MAG_W+3)'(sum_val);

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_phase
      always_ff @(posedge CLK)
      begin
        if (SYS_RST)
        begin
          over_upper_reg[gi] <= 1'b0;
          above_lower_reg[gi] <= 1'b0;
          below_lower_reg[gi] <= 1'b0;
        end
        else if (s1_valid_reg)
        begin
          over_upper_reg[gi] <= hyst_above(over_upper_reg[gi], ph[gi], upper_mem[grp_reg]);
          above_lower_reg[gi] <= hyst_above(above_lower_reg[gi], ph[gi], lower_mem[grp_reg]);
          below_lower_reg[gi] <= hyst_below(below_lower_reg[gi], ph[gi], lower_mem[grp_reg]);
        end
      end
    end
  endgenerate

  // Ratio and summation comparisons, no division needed
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      ratio_ok_reg <= 1'b0;
      seq_ok_reg <= 1'b0;
      sum_ok_reg <= 1'b0;
      s2_valid_reg <= 1'b0;
    end
    else
    begin
      s2_valid_reg <= s1_valid_reg;
      if (s1_valid_reg)
      begin
        ratio_ok_reg <= (24'(ph_min) << RATIO_SHIFT)
          < 24'(pratio_mem[grp_reg]) * 24'(ph_max);
        seq_ok_reg <= (24'(meas_reg.negative_sequence_current) << RATIO_SHIFT)
          > 24'(sratio_mem[grp_reg]) * 24'(meas_reg.positive_sequence_current);
        sum_ok_reg <= !ctrl_reg[CTRL_SUM_BIT]
          || (sum_abs > (MAG_W+3)'(sumdiff_mem[grp_reg]));
      end
    end
  end

  // ========================================================================
  // Stage 3: combined condition, held between measurement sets
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      cond_reg <= 1'b0;
    else if (s2_valid_reg)
      cond_reg <= !(|over_upper_reg) && (|above_lower_reg) && (|below_lower_reg)
        && ratio_ok_reg && seq_ok_reg && sum_ok_reg;
  end

  // ========================================================================
  // Stage 4: block check and delay timer
  logic [15:0] timer_reg;
  logic [15:0] act_delay;
  assign act_delay = delay_mem[grp_reg];

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:
        if (BLOCK_IN)
          state_next = ST_BLOCKED;
        else if (cond_reg)
          state_next = (act_delay == 16'h0000) ? ST_ALARM : ST_TIMING;
      ST_TIMING:
        if (BLOCK_IN)
          state_next = ST_BLOCKED;
        else if (!cond_reg)
          state_next = ST_IDLE;
        else if (ms_tick && timer_reg + 16'h0001 >= act_delay)
          state_next = ST_ALARM;
      ST_ALARM:
        if (BLOCK_IN)
          state_next = ST_BLOCKED;
        else if (!cond_reg)
          state_next = ST_IDLE;
      ST_BLOCKED:
        if (!BLOCK_IN)
          state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      state_reg <= ST_IDLE;
      timer_reg <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next;
      // Timer restarts whenever the timing state is left or not yet entered
      if (state_next != ST_TIMING || state_reg != ST_TIMING)
        timer_reg <= 16'h0000;
      else if (ms_tick)
        timer_reg <= timer_reg + 16'h0001;
    end
  end

  // ========================================================================
  // Stage 5: outputs, events, counters, interrupts
  logic alarm_next;
  logic blocked_next;
  logic [EV_W-1:0] ev_set;
  logic clr_wr;
  assign alarm_next = (state_next == ST_ALARM);
  assign blocked_next = (state_next == ST_BLOCKED);
  assign ev_set = {BLOCKED & !blocked_next, !BLOCKED & blocked_next,
                   ALARM & !alarm_next, !ALARM & alarm_next};
  assign clr_wr = wr_acc && PADDR == OFS_CNT_CLR;

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      ALARM <= 1'b0;
      BLOCKED <= 1'b0;
      EVT_VALID <= 1'b0;
      EVT <= '0;
    end
    else
    begin
      ALARM <= alarm_next;
      BLOCKED <= blocked_next;
      EVT_VALID <= |ev_set;
      EVT <= '{kind: ev_set, stamp: ms_count_reg};
    end
  end

  // A count landing with a clear still counts
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      alarm_cnt_reg <= 32'h0000_0000;
      block_cnt_reg <= 32'h0000_0000;
    end
    else
    begin
      if (ev_set[EV_ALARM_ON])
        alarm_cnt_reg <= (clr_wr && PWDATA[0]) ? 32'h0000_0001 : alarm_cnt_reg + 32'h0000_0001;
      else if (clr_wr && PWDATA[0])
        alarm_cnt_reg <= 32'h0000_0000;
      if (ev_set[EV_BLOCK_ON])
        block_cnt_reg <= (clr_wr && PWDATA[1]) ? 32'h0000_0001 : block_cnt_reg + 32'h0000_0001;
      else if (clr_wr && PWDATA[1])
        block_cnt_reg <= 32'h0000_0000;
    end
  end

  // Sticky status, write one to clear, new event wins
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      irq_stat_reg <= 4'h0;
    else if (wr_acc && PADDR == OFS_IRQ_STAT)
      irq_stat_reg <= (irq_stat_reg & ~PWDATA[EV_W-1:0]) | ev_set;
    else
      irq_stat_reg <= irq_stat_reg | ev_set;
  end

  assign IRQ = |(irq_stat_reg & irq_mask_reg);

  // ========================================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  property p_block_forces;
    BLOCK_IN |=> BLOCKED && !ALARM && timer_reg == 16'h0000;
  endproperty
  a_block_forces: assert property (p_block_forces) else $error("block not honoured");

  property p_upper_kills;
    s2_valid_reg && (|over_upper_reg) |=> !cond_reg;
  endproperty
  a_upper_kills: assert property (p_upper_kills) else $error("upper limit ignored");

  property p_lower_both;
    $rose(cond_reg) |-> $past(|above_lower_reg) && $past(|below_lower_reg);
  endproperty
  a_lower_both: assert property (p_lower_both) else $error("lower limit pair missing");

  property p_alarm_cause;
    $rose(ALARM) |-> $past(cond_reg) && !$past(BLOCK_IN)
      && ($past(act_delay) == 16'h0000 || $past(state_reg) == ST_TIMING);
  endproperty
  a_alarm_cause: assert property (p_alarm_cause) else $error("alarm without delay");

  property p_drop;
    ALARM && !cond_reg |=> !ALARM;
  endproperty
  a_drop: assert property (p_drop) else $error("alarm held after loss");

  property p_event;
    $rose(ALARM) |-> EVT_VALID && EVT.kind[EV_ALARM_ON] && EVT.stamp == $past(ms_count_reg);
  endproperty
  a_event: assert property (p_event) else $error("alarm on event missing");

  property p_count;
    $rose(BLOCKED) && !$past(clr_wr) |-> block_cnt_reg == $past(block_cnt_reg) + 32'h0000_0001;
  endproperty
  a_count: assert property (p_count) else $error("blocked count wrong");

  property p_capture;
    MEAS_VALID |=> s1_valid_reg ##1 s2_valid_reg;
  endproperty
  a_capture: assert property (p_capture) else $error("capture stage skipped");

  property p_res_none;
    s1_valid_reg && $past(ctrl_reg[1:0]) == RES_NONE |-> res_mag_reg == '0;
  endproperty
  a_res_none: assert property (p_res_none) else $error("residual not zeroed");
endmodule
`default_nettype wire

/* tb/ctsv_front_end.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Measurement front end: one magnitude set per time base
module ctsv_front_end
  import ctsv_pkg::*;
#(
  parameter int PERIOD = 50
)(
  input wire logic clk,
  input wire logic rst,
  input wire ctsv_meas_t set_in,
  output logic meas_valid,
  output ctsv_meas_t meas
);
  int cnt_reg;
  ctsv_meas_t held_reg;
  // Strobe once per base period, latch the set beside it
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_reg <= 0;
      meas_valid <= 1'b0;
    end
    else
    begin
      cnt_reg <= (cnt_reg == PERIOD - 1) ? 0 : cnt_reg + 1;
      meas_valid <= (cnt_reg == PERIOD - 1);
    end
    held_reg <= set_in;
  end
  // Off the strobe the bus carries junk, so a late capture shows up
  assign meas = meas_valid ? held_reg : ~held_reg;
endmodule
`default_nettype wire

/* tb/ctsv_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Self-checking bench for the supervisor
module ctsv_top_test
  import ctsv_pkg::*;
;
  logic CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic MEAS_VALID;
  ctsv_meas_t MEAS;
  logic BLOCK_IN = 1'b0;
  logic [GRP_W-1:0] GROUP_SEL = 3'h0;
  logic ALARM;
  logic BLOCKED;
  logic EVT_VALID;
  ctsv_event_t EVT;
  logic IRQ;
  ctsv_meas_t set_now = '0;
  logic [3:0] exp_q[$];
  logic [31:0] rdat;
  logic rerr;
  logic [15:0] amp;
  logic [2:0] grp;
  logic [15:0] neg_seq = 16'h0190;
  int failures = 0;
  int checks = 0;
  int cycles = 0;

  always #20 CLK = ~CLK;

  ctsv_front_end #(.PERIOD(50)) feed (.clk(CLK), .rst(SYS_RST), .set_in(set_now),
    .meas_valid(MEAS_VALID), .meas(MEAS));

  ctsv_top #(.TICK_CYCLES(10)) DUT (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .MEAS_VALID(MEAS_VALID), .MEAS(MEAS),
    .BLOCK_IN(BLOCK_IN), .GROUP_SEL(GROUP_SEL), .ALARM(ALARM), .BLOCKED(BLOCKED),
    .EVT_VALID(EVT_VALID), .EVT(EVT), .IRQ(IRQ));

  // ==========================================================
  // Compare and close
  task stop_test;
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %0t level %b expected %b", $time, got, exp);
    end
  endtask

  // ==========================================================
  // Bus and stimulus helpers
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rdat = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask

  // Positive sequence fixed at 600, negative from neg_seq; both residual inputs carry r
  task meas(input logic [15:0] a, input logic [15:0] c, input logic [15:0] r);
    set_now <= {a, a, c, r, r, 16'h0258, neg_seq};
  endtask

  // Event order is fixed, so a drained queue marks completion
  task wait_q;
    while (exp_q.size() != 0) @(posedge CLK);
    repeat (2) @(posedge CLK);
  endtask

  // ==========================================================
  // Event monitor and hang guard
  always @(posedge CLK)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      failures++;
      stop_test();
    end
    if (EVT_VALID === 1'b1)
      chk({28'h0, EVT.kind}, exp_q.size() ? {28'h0, exp_q.pop_front()} : 32'hFFFFFFFF);
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    void'($urandom(29));
    amp = 16'h012C + 16'($urandom % 32'h2BC);
    grp = 3'($urandom % 32'h8);
    repeat (5) @(posedge CLK);
    SYS_RST <= 1'b0;
    rd(OFS_STATUS, 32'h0);
    rd(OFS_SET_BASE, {16'h0000, UPPER_RST});
    apb(1'b0, 12'h200, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    for (int g = 0; g < 8; g++)
      apb(1'b1, OFS_SET_BASE + 12'(g * 32) + 12'h014, 32'h2);
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    GROUP_SEL <= grp;
    // Open phase c: alarm after the 2 ms delay
    meas(amp, 16'h0000, 16'h0000);
    exp_q.push_back(4'h1);
    wait_q();
    chk1(ALARM, 1'b1);
    chk1(IRQ, 1'b1);
    rd(OFS_STATUS, {24'h0, grp, 2'b11, 1'b1, 1'b0, 1'b1});
    meas(amp, amp, 16'h0000);
    exp_q.push_back(4'h2);
    wait_q();
    chk1(ALARM, 1'b0);
    // Overcurrent phase, then all phases above the lower limit
    meas(16'h07D0, 16'h0000, 16'h0000);
    repeat (150) @(posedge CLK);
    chk1(ALARM, 1'b0);
    meas(16'h03E7, 16'h0096, 16'h0000);
    repeat (150) @(posedge CLK);
    chk1(ALARM, 1'b0);
    // Low negative sequence share: 100/600 is under the half limit
    neg_seq = 16'h0064;
    meas(amp, 16'h0000, 16'h0000);
    repeat (150) @(posedge CLK);
    chk1(ALARM, 1'b0);
    neg_seq = 16'h0190;
    // Residual input one cancels the sum when subtracted
    apb(1'b1, OFS_CTRL, 32'hD);
    meas(amp, 16'h0000, 16'(amp * 2));
    repeat (150) @(posedge CLK);
    chk1(ALARM, 1'b0);
    // Second residual input selected, still subtracted: sum stays cancelled
    apb(1'b1, OFS_CTRL, 32'hE);
    repeat (150) @(posedge CLK);
    chk1(ALARM, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h9);
    exp_q.push_back(4'h1);
    wait_q();
    chk1(ALARM, 1'b1);
    meas(amp, amp, 16'h0000);
    exp_q.push_back(4'h2);
    wait_q();
    // Blocking overrides a qualifying fault
    BLOCK_IN <= 1'b1;
    exp_q.push_back(4'h4);
    wait_q();
    chk1(BLOCKED, 1'b1);
    meas(amp, 16'h0000, 16'h0000);
    repeat (150) @(posedge CLK);
    chk1(ALARM, 1'b0);
    BLOCK_IN <= 1'b0;
    exp_q.push_back(4'h8);
    exp_q.push_back(4'h1);
    wait_q();
    chk1(ALARM, 1'b1);
    rd(OFS_ALARM_CNT, 32'h3);
    rd(OFS_BLOCK_CNT, 32'h1);
    apb(1'b1, OFS_CNT_CLR, 32'h3);
    rd(OFS_ALARM_CNT, 32'h0);
    rd(OFS_BLOCK_CNT, 32'h0);
    rd(OFS_IRQ_STAT, 32'hF);
    apb(1'b1, OFS_IRQ_STAT, 32'hF);
    // Clear lands at the access edge; look one cycle later
    @(posedge CLK);
    chk1(IRQ, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
